// [cond_defines.svh]
`ifndef COND_DEFINES_SVH
`define COND_DEFINES_SVH

// status bit positions in program_counter_status
`define PCS_N_BIT 31
`define PCS_Z_BIT 30
`define PCS_C_BIT 29
`define PCS_V_BIT 28
`define PCS_I_BIT 27
`define PCS_F_BIT 26
`define PCS_PC_MSB 25
`define PCS_PC_LSB 2
`define PCS_PC_WIDTH 24
`define PCS_MODE_MSB 1
`define PCS_MODE_LSB 0
// interrupts masked, supervisor state, pc at zero
`define PCS_RESET 32'h0C00_0003
`define PC_STEP 24'h00_0001

// instruction word fields
`define COND_MSB 31
`define COND_LSB 28
`define OP_CLASS_MSB 27
`define OP_CLASS_LSB 26
`define OP_CLASS_DATA 2'h0
`define IMM_FLAG_BIT 25
`define ROT_MSB 11
`define ROT_LSB 8
`define IMM8_MSB 7
`define IMM8_LSB 0
`define SHIFT_SRC_BIT 4
`define SHIFT_AMT_MSB 11
`define SHIFT_AMT_LSB 7
`define SHIFT_REG_MSB 11
`define SHIFT_REG_LSB 8

// reserved opcode patterns
`define RSV_A_MSB 27
`define RSV_A_LSB 24
`define RSV_A_VALUE 4'h1
`define RSV_A_BIT_HI 7
`define RSV_A_BIT_LO 4
`define RSV_B_MSB 27
`define RSV_B_LSB 25
`define RSV_B_VALUE 3'h3
`define RSV_B_BIT 4

`endif

// [cond_pkg.sv]
package cond_pkg;

	typedef enum logic [3:0] {
		cond_equal = 4'h0,
		cond_not_equal = 4'h1,
		cond_carry_set = 4'h2,
		cond_carry_clear = 4'h3,
		cond_negative = 4'h4,
		cond_non_negative = 4'h5,
		cond_overflow = 4'h6,
		cond_no_overflow = 4'h7,
		cond_unsigned_higher = 4'h8,
		cond_unsigned_lower_same = 4'h9,
		cond_signed_ge = 4'hA,
		cond_signed_lt = 4'hB,
		cond_signed_gt = 4'hC,
		cond_signed_le = 4'hD,
		cond_always = 4'hE,
		cond_never = 4'hF
	} cond_e;

	typedef logic [1:0] mode_t;

endpackage : cond_pkg

// [imm_rot_if.sv]
`timescale 1ns/1ps
interface imm_rot_if;
	logic [7:0] imm8;
	logic [3:0] rot;
	logic [31:0] value;

	modport requester (output imm8, output rot, input value);
	modport rotator (input imm8, input rot, output value);
endinterface : imm_rot_if

// [immediate_rotator.sv]
`timescale 1ns/1ps
module immediate_rotator (
	input wire logic sys_clk, // core clock
	input wire logic srst, // synchronous reset
	imm_rot_if.rotator rot_port // constant and rotation in, value out
);
	logic [31:0] value_reg;
	logic [31:0] value_next;
	logic [63:0] doubled;
	logic [4:0] amount;

	// rotate right by twice the field, so wrapped patterns rebuild too
	assign amount = {rot_port.rot, 1'b0};
	assign doubled = {24'h00_0000, rot_port.imm8, 24'h00_0000, rot_port.imm8};
	assign value_next = doubled[amount +: 32];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			value_reg <= 32'h0000_0000;
		end else begin
			value_reg <= value_next;
		end
	end

	assign rot_port.value = value_reg;
endmodule : immediate_rotator

// [condition_check_and_flags.sv]
// Operation
// - execute only when condition field passes
// - negative flag takes result bit 31
// - zero flag on zero result, compares too
// - carry from arithmetic; logic clears or keeps
// - overflow on same-sign operands, flipped result
// - bit 27 set blocks normal interrupts
// - bit 26 set blocks fast interrupts
// - bits 1:0 hold execution state
// - 0000 zero set, 0001 zero clear
// - 0010 carry set, 0011 carry clear
// - 0100 negative set, 0101 negative clear
// - 0110 overflow set, 0111 overflow clear
// - 1000 C and not Z; 1001 otherwise
// - 1010 N equals V; 1011 N differs
// - 1100 not Z, N=V; 1101 opposite
// - 1110 always passes, 1111 never passes
// - bits 27:24 0001, bits 7,4 set reserved
// - bits 27:25 011, bit 4 set reserved
// - reserved words with 1111 dropped silently
// - shift count from constant or register
// - rotate eight-bit constant across 32 bits
`timescale 1ns/1ps
`include "cond_defines.svh"

module condition_check_and_flags (
	input wire logic sys_clk, // core clock, 100 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic fetch_valid, // instruction word presented this cycle
	input wire logic [31:0] fetch_word, // fetched instruction word
	input wire logic alu_valid, // executed instruction finishing in alu
	input wire logic alu_set_flags, // instruction updates flags
	input wire logic alu_arith, // arithmetic op, carry and overflow valid
	input wire logic alu_logic_keeps_c, // logic op leaves carry alone
	input wire logic [31:0] alu_result, // alu result word
	input wire logic alu_carry_out, // carry out of result bit 31
	input wire logic [31:0] alu_operand_a, // first addend
	input wire logic [31:0] alu_operand_b, // effective second addend
	input wire logic status_wr_en, // load program_counter_status
	input wire logic [31:0] status_wr_data, // value to load
	input wire logic irq_request, // normal interrupt request level
	input wire logic fast_interrupt_request, // fast interrupt request level
	output logic [31:0] program_counter_status, // flags, masks, pc, mode
	output logic issue_execute, // instruction passed, execute it
	output logic issue_skip, // instruction failed, slot consumed
	output logic undefined_event, // reserved word passed its condition
	output logic [31:0] issue_word, // word belonging to this slot
	output logic op2_is_immediate, // second operand is rotated constant
	output logic [31:0] op2_immediate, // rotated constant
	output logic shift_by_register, // shift count comes from a register
	output logic [4:0] shift_amount, // constant shift count
	output logic [3:0] shift_count_reg_sel, // register holding shift count
	output logic irq_accept, // normal interrupt taken
	output logic fast_irq_accept // fast interrupt taken
);

	// ---------------------------------------------------------------
	// status register
	// ---------------------------------------------------------------
	logic [31:0] pcs_reg;
	logic [31:0] pcs_next;
	logic flag_n;
	logic flag_z;
	logic flag_c;
	logic flag_v;
	logic mask_irq;
	logic mask_fast;
	cond_pkg::mode_t exec_mode;

	assign flag_n = pcs_reg[`PCS_N_BIT];
	assign flag_z = pcs_reg[`PCS_Z_BIT];
	assign flag_c = pcs_reg[`PCS_C_BIT];
	assign flag_v = pcs_reg[`PCS_V_BIT];
	assign mask_irq = pcs_reg[`PCS_I_BIT];
	assign mask_fast = pcs_reg[`PCS_F_BIT];
	assign exec_mode = pcs_reg[`PCS_MODE_MSB:`PCS_MODE_LSB];

	// ---------------------------------------------------------------
	// condition evaluation
	// ---------------------------------------------------------------
	logic [3:0] cond_field;
	logic [15:0] cond_table;
	logic cond_pass;
	logic n_matches_v;

	assign cond_field = fetch_word[`COND_MSB:`COND_LSB];
	assign n_matches_v = (flag_n == flag_v);

	assign cond_table[cond_pkg::cond_equal] = flag_z;
	assign cond_table[cond_pkg::cond_not_equal] = ~flag_z;
	assign cond_table[cond_pkg::cond_carry_set] = flag_c;
	assign cond_table[cond_pkg::cond_carry_clear] = ~flag_c;
	assign cond_table[cond_pkg::cond_negative] = flag_n;
	assign cond_table[cond_pkg::cond_non_negative] = ~flag_n;
	assign cond_table[cond_pkg::cond_overflow] = flag_v;
	assign cond_table[cond_pkg::cond_no_overflow] = ~flag_v;
	assign cond_table[cond_pkg::cond_unsigned_higher] = flag_c & ~flag_z;
	assign cond_table[cond_pkg::cond_unsigned_lower_same] = ~flag_c | flag_z;
	// signed greater-or-equal is the plain N equals V test
	assign cond_table[cond_pkg::cond_signed_ge] = n_matches_v;
	assign cond_table[cond_pkg::cond_signed_lt] = ~n_matches_v;
	assign cond_table[cond_pkg::cond_signed_gt] = ~flag_z & n_matches_v;
	assign cond_table[cond_pkg::cond_signed_le] = flag_z | ~n_matches_v;
	assign cond_table[cond_pkg::cond_always] = 1'b1;
	assign cond_table[cond_pkg::cond_never] = 1'b0;

	assign cond_pass = cond_table[cond_field];

	// ---------------------------------------------------------------
	// reserved pattern detection
	// ---------------------------------------------------------------
	logic rsv_a;
	logic rsv_b;
	logic reserved_word;

	assign rsv_a = (fetch_word[`RSV_A_MSB:`RSV_A_LSB] == `RSV_A_VALUE)
		& fetch_word[`RSV_A_BIT_HI] & fetch_word[`RSV_A_BIT_LO];
	assign rsv_b = (fetch_word[`RSV_B_MSB:`RSV_B_LSB] == `RSV_B_VALUE)
		& fetch_word[`RSV_B_BIT];
	assign reserved_word = rsv_a | rsv_b;

	// ---------------------------------------------------------------
	// slot outcome
	// ---------------------------------------------------------------
	logic execute_next;
	logic skip_next;
	logic undef_next;

	// condition is checked before the pattern, so 1111 reserved words
	// simply fall into the skip path and never fault
	assign execute_next = fetch_valid & cond_pass & ~reserved_word;
	assign undef_next = fetch_valid & cond_pass & reserved_word;
	assign skip_next = fetch_valid & ~cond_pass;

	// ---------------------------------------------------------------
	// operand forms
	// ---------------------------------------------------------------
	logic data_class;
	logic imm_form_next;
	logic shift_reg_next;
	logic [4:0] shift_amt_next;
	logic [3:0] shift_sel_next;

	assign data_class = (fetch_word[`OP_CLASS_MSB:`OP_CLASS_LSB] == `OP_CLASS_DATA);
	assign imm_form_next = data_class & fetch_word[`IMM_FLAG_BIT];
	// register-sourced count only for shifted register operands
	assign shift_reg_next = data_class & ~fetch_word[`IMM_FLAG_BIT]
		& fetch_word[`SHIFT_SRC_BIT];
	assign shift_amt_next = fetch_word[`SHIFT_AMT_MSB:`SHIFT_AMT_LSB];
	assign shift_sel_next = fetch_word[`SHIFT_REG_MSB:`SHIFT_REG_LSB];

	imm_rot_if rot_bus ();

	assign rot_bus.imm8 = fetch_word[`IMM8_MSB:`IMM8_LSB];
	assign rot_bus.rot = fetch_word[`ROT_MSB:`ROT_LSB];

	immediate_rotator u_rotator (
		.sys_clk (sys_clk),
		.srst (srst),
		.rot_port (rot_bus.rotator)
	);

	// ---------------------------------------------------------------
	// flag update from alu
	// ---------------------------------------------------------------
	logic flag_update;
	logic n_next;
	logic z_next;
	logic c_next;
	logic v_next;
	logic same_sign;
	logic sign_flip;

	// skipped slots never reach the alu, so no alu_valid arrives
	assign flag_update = alu_valid & alu_set_flags;
	assign n_next = alu_result[31];
	assign z_next = (alu_result == 32'h0000_0000);
	assign same_sign = (alu_operand_a[31] == alu_operand_b[31]);
	assign sign_flip = (alu_result[31] != alu_operand_a[31]);
	// logic ops never make a carry: clear it unless told to keep
	assign c_next = alu_arith ? alu_carry_out
		: (alu_logic_keeps_c & flag_c);
	assign v_next = alu_arith ? (same_sign & sign_flip) : flag_v;

	// ---------------------------------------------------------------
	// next status value
	// ---------------------------------------------------------------
	logic [`PCS_PC_WIDTH-1:0] pc_word;
	logic [`PCS_PC_WIDTH-1:0] pc_step;
	logic [31:0] pcs_loaded;

	// pc counts words, so a byte address is always aligned
	assign pc_word = pcs_reg[`PCS_PC_MSB:`PCS_PC_LSB];
	assign pc_step = fetch_valid ? (pc_word + `PC_STEP) : pc_word;
	assign pcs_loaded = status_wr_en ? status_wr_data
		: {pcs_reg[31:`PCS_PC_MSB+1], pc_step, pcs_reg[`PCS_MODE_MSB:0]};

	// an alu flag update in the same cycle as a load wins for the flags
	always_comb begin
		pcs_next = pcs_loaded;
		if (flag_update) begin
			pcs_next[`PCS_N_BIT] = n_next;
			pcs_next[`PCS_Z_BIT] = z_next;
			pcs_next[`PCS_C_BIT] = c_next;
			pcs_next[`PCS_V_BIT] = v_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pcs_reg <= `PCS_RESET;
		end else begin
			pcs_reg <= pcs_next;
		end
	end

	// ---------------------------------------------------------------
	// interrupt acceptance
	// ---------------------------------------------------------------
	logic irq_accept_reg;
	logic irq_accept_next;
	logic fast_accept_reg;
	logic fast_accept_next;

	assign irq_accept_next = irq_request & ~mask_irq;
	assign fast_accept_next = fast_interrupt_request & ~mask_fast;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_accept_reg <= 1'b0;
			fast_accept_reg <= 1'b0;
		end else begin
			irq_accept_reg <= irq_accept_next;
			fast_accept_reg <= fast_accept_next;
		end
	end

	// ---------------------------------------------------------------
	// issue stage registers
	// ---------------------------------------------------------------
	logic execute_reg;
	logic skip_reg;
	logic undef_reg;
	logic [31:0] word_reg;
	logic [31:0] word_next;
	logic imm_form_reg;
	logic shift_reg_reg;
	logic [4:0] shift_amt_reg;
	logic [3:0] shift_sel_reg;

	// word held between slots so downstream sees a stable value
	assign word_next = fetch_valid ? fetch_word : word_reg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			execute_reg <= 1'b0;
			skip_reg <= 1'b0;
			undef_reg <= 1'b0;
		end else begin
			execute_reg <= execute_next;
			skip_reg <= skip_next;
			undef_reg <= undef_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			word_reg <= 32'h0000_0000;
			imm_form_reg <= 1'b0;
			shift_reg_reg <= 1'b0;
			shift_amt_reg <= 5'h00;
			shift_sel_reg <= 4'h0;
		end else begin
			word_reg <= word_next;
			imm_form_reg <= imm_form_next;
			shift_reg_reg <= shift_reg_next;
			shift_amt_reg <= shift_amt_next;
			shift_sel_reg <= shift_sel_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------------------------
	assign program_counter_status = pcs_reg;
	assign issue_execute = execute_reg;
	assign issue_skip = skip_reg;
	assign undefined_event = undef_reg;
	assign issue_word = word_reg;
	assign op2_is_immediate = imm_form_reg;
	assign op2_immediate = rot_bus.value;
	assign shift_by_register = shift_reg_reg;
	assign shift_amount = shift_amt_reg;
	assign shift_count_reg_sel = shift_sel_reg;
	assign irq_accept = irq_accept_reg;
	assign fast_irq_accept = fast_accept_reg;

endmodule : condition_check_and_flags

// [condition_check_and_flags_props.sv]
`timescale 1ns/1ps
module condition_check_and_flags_props (
	input wire logic sys_clk, // clock
	input wire logic srst, // reset
	input wire logic fetch_valid, // slot strobe
	input wire logic [31:0] fetch_word, // word
	input wire logic alu_valid, // alu done
	input wire logic alu_set_flags, // flag update
	input wire logic alu_arith, // arith op
	input wire logic [31:0] alu_result, // result
	input wire logic alu_carry_out, // carry
	input wire logic [31:0] alu_operand_a, // addend
	input wire logic [31:0] alu_operand_b, // addend
	input wire logic status_wr_en, // status write
	input wire logic [31:0] status_wr_data, // write data
	input wire logic irq_request, // irq
	input wire logic fast_interrupt_request, // fast irq
	input wire logic [31:0] program_counter_status, // status
	input wire logic issue_execute, // passed
	input wire logic issue_skip, // failed
	input wire logic undefined_event, // reserved passed
	input wire logic irq_accept, // irq taken
	input wire logic fast_irq_accept // fast irq taken
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic [31:0] pcs = program_counter_status;
	wire logic upd = alu_valid && alu_set_flags;
	wire logic [3:0] cond_code = fetch_word[31:28];
	wire logic rsv_a = fetch_word[27:24] == 4'h1 && fetch_word[7] && fetch_word[4];
	wire logic rsv_b = fetch_word[27:25] == 3'h3 && fetch_word[4];
	wire logic ovf = alu_operand_a[31] == alu_operand_b[31] && alu_result[31] != alu_operand_a[31];
	a_one_outcome: assert property (fetch_valid |=>
		$onehot({issue_execute, issue_skip, undefined_event})) else $error("slot outcome bad");
	a_never_code: assert property (fetch_valid && cond_code == 4'hF |=> issue_skip)
		else $error("never code not skipped");
	a_always_code: assert property (fetch_valid && cond_code == 4'hE && !rsv_a && !rsv_b
		|=> issue_execute) else $error("always code not executed");
	a_reserved_a: assert property (fetch_valid && cond_code == 4'hE && rsv_a
		|=> undefined_event) else $error("first reserved pattern missed");
	a_reserved_b: assert property (fetch_valid && cond_code == 4'hE && rsv_b
		|=> undefined_event) else $error("second reserved pattern missed");
	a_neg_flag: assert property (upd |=> pcs[31] == $past(alu_result[31]))
		else $error("negative flag wrong");
	a_zero_flag: assert property (upd |=> pcs[30] == ($past(alu_result) == 32'h0))
		else $error("zero flag wrong");
	a_carry_flag: assert property (upd && alu_arith |=> pcs[29] == $past(alu_carry_out))
		else $error("carry flag wrong");
	a_ovf_flag: assert property (upd && alu_arith |=> pcs[28] == $past(ovf))
		else $error("overflow flag wrong");
	a_irq_masked: assert property (irq_request && pcs[27] |=> !irq_accept)
		else $error("masked irq accepted");
	a_irq_taken: assert property (irq_request && !pcs[27] |=> irq_accept)
		else $error("open irq not accepted");
	a_fast_masked: assert property (fast_interrupt_request && pcs[26] |=> !fast_irq_accept)
		else $error("masked fast irq accepted");
	a_mode_write: assert property (status_wr_en |=> pcs[1:0] == $past(status_wr_data[1:0]))
		else $error("mode not written");
	a_skip_keeps: assert property (fetch_valid && cond_code == 4'hF && !upd && !status_wr_en
		|=> $stable(pcs[31:26]) && $stable(pcs[1:0])) else $error("skip changed state");
	c_execute: cover property (issue_execute);
	c_skip: cover property (issue_skip);
	c_undefined: cover property (undefined_event);
endmodule : condition_check_and_flags_props

bind condition_check_and_flags condition_check_and_flags_props i_props (.*);

// [core_side_model.sv]
`timescale 1ns/1ps
module core_side_model (
	input wire logic sys_clk, // clock
	output logic fetch_valid, // slot strobe
	output logic [31:0] fetch_word, // word
	output logic alu_valid, // alu done
	output logic alu_set_flags, // flag update
	output logic alu_arith, // arith op
	output logic alu_logic_keeps_c, // keep carry
	output logic [31:0] alu_result, // result
	output logic alu_carry_out, // carry
	output logic [31:0] alu_operand_a, // addend
	output logic [31:0] alu_operand_b // addend
);
	logic [31:0] fetch_addr;
	initial begin
		{fetch_valid, alu_valid, alu_set_flags, alu_arith, alu_logic_keeps_c} = '0;
		{alu_carry_out, fetch_word, alu_result, alu_operand_a, alu_operand_b} = '0;
		fetch_addr = 32'h0;
	end
	task automatic fetch(input logic [31:0] w);
		@(negedge sys_clk);
		fetch_valid <= 1'b1;
		fetch_word <= w;
		fetch_addr <= fetch_addr + 32'h4;
		@(negedge sys_clk);
		fetch_valid <= 1'b0;
		// a released bus must not look like a held word
		fetch_word <= ~w;
	endtask : fetch
	task automatic alu(input logic ar, input logic kc, input logic sf, input logic [31:0] a,
		input logic [31:0] b);
		@(negedge sys_clk);
		{alu_valid, alu_set_flags, alu_arith, alu_logic_keeps_c} <= {1'b1, sf, ar, kc};
		{alu_operand_a, alu_operand_b} <= {a, b};
		// logic ops raise a stray carry so keep and clear both show
		{alu_carry_out, alu_result} <= ar ? {1'b0, a} + {1'b0, b} : {1'b1, a & b};
		@(negedge sys_clk);
		alu_valid <= 1'b0;
		{alu_operand_a, alu_operand_b, alu_result} <= ~{a, b, alu_result};
	endtask : alu
endmodule : core_side_model

// [condition_check_and_flags_tb.sv]
`timescale 1ns/1ps
module condition_check_and_flags_tb;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic status_wr_en = 1'b0;
	logic [31:0] status_wr_data = 32'h0;
	logic irq_request = 1'b0;
	logic fast_interrupt_request = 1'b0;
	logic fetch_valid, alu_valid, alu_set_flags, alu_arith, alu_logic_keeps_c, alu_carry_out;
	logic [31:0] fetch_word, alu_result, alu_operand_a, alu_operand_b;
	logic [31:0] program_counter_status, issue_word, op2_immediate;
	logic issue_execute, issue_skip, undefined_event, op2_is_immediate, shift_by_register;
	logic irq_accept, fast_irq_accept;
	logic [4:0] shift_amount;
	logic [3:0] shift_count_reg_sel;
	int fails = 0;
	int num_checks = 0;
	always #5 sys_clk = ~sys_clk;
	core_side_model i_core (.*);
	condition_check_and_flags i_dut (.*);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic status_write(input logic [31:0] d);
		@(negedge sys_clk);
		status_wr_en <= 1'b1;
		status_wr_data <= d;
		@(negedge sys_clk);
		status_wr_en <= 1'b0;
		status_wr_data <= ~d;
	endtask : status_write
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		logic n, z, cy, v;
		{n, z, cy, v} = f;
		case (c[3:1])
			3'h0: cond_ok = z;
			3'h1: cond_ok = cy;
			3'h2: cond_ok = n;
			3'h3: cond_ok = v;
			3'h4: cond_ok = cy && !z;
			3'h5: cond_ok = n == v;
			3'h6: cond_ok = !z && n == v;
			default: cond_ok = 1'b1;
		endcase
		cond_ok = cond_ok ^ c[0];
	endfunction : cond_ok
	function automatic logic [3:0] flags_exp(input logic ar, input logic kc, input logic [31:0] a,
		input logic [31:0] b, input logic [1:0] p);
		logic [32:0] s;
		logic [31:0] r;
		s = {1'b0, a} + {1'b0, b};
		r = ar ? s[31:0] : a & b;
		flags_exp = {r[31], r == 32'h0, ar ? s[32] : kc & p[1],
			ar ? a[31] == b[31] && r[31] != a[31] : p[0]};
	endfunction : flags_exp
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		report_and_stop();
	end
	initial begin
		logic [31:0] d, w, a, b, prev;
		logic [63:0] rot;
		logic [3:0] exp;
		logic ok, ar, sf;
		void'($urandom(6997));
		repeat (20) @(negedge sys_clk);
		chk("reset status", 32'h0C00_0003, program_counter_status);
		srst <= 1'b0;
		for (int i = 0; i < 256; i++) begin
			d = {i[3:0], 2'h0, 24'($urandom), 2'($urandom)};
			status_write(d);
			w = {i[7:4], 28'($urandom) & 28'hFFF_FFEF};
			i_core.fetch(w);
			ok = cond_ok(w[31:28], d[31:28]);
			chk("execute", ok, issue_execute);
			chk("skip", !ok, issue_skip);
			chk("status", {d[31:26], d[25:2] + 24'h1, d[1:0]}, program_counter_status);
			chk("word", w, issue_word);
		end
		$display("done: conditions");
		for (int i = 0; i < 48; i++) begin
			{a, b} = {32'($urandom), 32'($urandom)};
			if (i == 1) {a, b} = {32'h7FFF_FFFF, 32'h1};
			if (i == 2) {a, b} = {32'h8000_0000, 32'h8000_0000};
			if (i == 3) {a, b} = {32'hFFFF_FFFF, 32'h1};
			if (i == 0) {a, b} = 64'h0;
			ar = i < 4 || i[0];
			sf = i % 6 != 5;
			prev = program_counter_status;
			i_core.alu(ar, i[1], sf, a, b);
			exp = sf ? flags_exp(ar, i[1], a, b, prev[29:28]) : prev[31:28];
			chk("flags", {exp, prev[27:0]}, program_counter_status);
		end
		$display("done: flags");
		for (int k = 0; k < 8; k++) begin
			w = k[0] ? ($urandom & 32'h01FF_FFEF) | 32'h0600_0010
				: ($urandom & 32'h00FF_FF6F) | 32'h0100_0090;
			w[31:28] = k[1] ? 4'hF : 4'hE;
			i_core.fetch(w);
			chk("undefined", !k[1], undefined_event);
			chk("skip", k[1], issue_skip);
			chk("execute", 1'b0, issue_execute);
		end
		$display("done: reserved");
		for (int k = 0; k < 24; k++) begin
			w = ($urandom & 32'h03FF_FFFF) | 32'hE000_0000;
			if (k == 0) w = 32'hE200_01FF;
			i_core.fetch(w);
			rot = {24'h0, w[7:0], 24'h0, w[7:0]} >> {w[11:8], 1'b0};
			chk("immediate flag", w[25], op2_is_immediate);
			if (w[25])
				chk("immediate", rot[31:0], op2_immediate);
			chk("shift source", !w[25] && w[4], shift_by_register);
			chk("shift count", w[11:7], shift_amount);
			chk("shift reg", w[11:8], shift_count_reg_sel);
		end
		$display("done: operands");
		for (int m = 0; m < 4; m++) begin
			status_write({6'(m), 24'h0, 2'h3});
			@(negedge sys_clk);
			irq_request <= 1'b1;
			fast_interrupt_request <= 1'b1;
			@(negedge sys_clk);
			chk("irq", !m[1], irq_accept);
			chk("fast irq", !m[0], fast_irq_accept);
			irq_request <= 1'b0;
			fast_interrupt_request <= 1'b0;
		end
		$display("done: interrupts");
		report_and_stop();
	end
endmodule : condition_check_and_flags_tb
